// ==== src/ppdc_regs.vh ====
// Constants of the port pad driver control bank: register indices, short
// aliases, field positions, codes, masks and reset values.
// Assumes it is included by bare name from the design files under src/.
`ifndef PPDC_REGS_VH
`define PPDC_REGS_VH

// Register indices as printed; byte address is four times the index
`define PPDC_IDX_P0L        16'hf080
`define PPDC_IDX_P0H        16'hf082
`define PPDC_IDX_P1L        16'hf084
`define PPDC_IDX_P1H        16'hf086
`define PPDC_IDX_P2         16'hf088
`define PPDC_IDX_P3         16'hf08a
`define PPDC_IDX_P4         16'hf08c
`define PPDC_IDX_P6         16'hf08e
`define PPDC_IDX_P7         16'hf090
`define PPDC_IDX_P8         16'hf092

// Short 8-bit aliases of the same registers, first and last
`define PPDC_SHORT_FIRST    8'h40
`define PPDC_SHORT_LAST     8'h49

// Number of registers in the bank
`define PPDC_NREG           4'ha

// Field layout inside one nibble pair (four bits per nibble)
`define PPDC_EDGE_LSB       0
`define PPDC_DRIVE_LSB      2
`define PPDC_PAIR_BITS      4

// Edge codes
`define PPDC_EDGE_FAST      2'h0
`define PPDC_EDGE_SLOW      2'h1

// Drive codes
`define PPDC_DRV_HIGH       2'h0
`define PPDC_DRV_DYNAMIC    2'h1
`define PPDC_DRV_LOW        2'h2

// Writable bits of two- and four-nibble registers
`define PPDC_MASK_NARROW    16'h00ff
`define PPDC_MASK_WIDE      16'hffff

// Reset value of every register
`define PPDC_RESET_VALUE    16'h0000

// AHB-Lite encodings used by the slave
`define PPDC_HTRANS_NONSEQ  2'h2
`define PPDC_HRESP_OKAY     1'h0

`endif

// ==== src/ppdc_nibble_decode.v ====
// Decoder from one pad control register to per-nibble pad driver modes.
// Assumes reserved codes already reach it and treats them as the reset mode.
`timescale 1ns/1ps
`include "ppdc_regs.vh"

module ppdc_nibble_decode (
  input  wire [15:0] ctl_value,
  output reg  [3:0]  slow_edge,
  output reg  [3:0]  dynamic_drive,
  output reg  [3:0]  low_drive
);

  integer     n;
  reg  [1:0]  edge_code;
  reg  [1:0]  drive_code;

  // Pair n steers pins 4n+3..4n of its port
  always @* begin
    edge_code     = 2'h0;
    drive_code    = 2'h0;
    slow_edge     = 4'h0;
    dynamic_drive = 4'h0;
    low_drive     = 4'h0;
    for (n = 0; n < 4; n = n + 1) begin
      edge_code  = ctl_value[n*`PPDC_PAIR_BITS + `PPDC_EDGE_LSB +: 2];
      drive_code = ctl_value[n*`PPDC_PAIR_BITS + `PPDC_DRIVE_LSB +: 2];
      // Reserved edge codes fall back to fast, the safe bus-capable choice
      slow_edge[n]     = (edge_code == `PPDC_EDGE_SLOW);
      // High current is the default: neither reduced mode asserted
      dynamic_drive[n] = (drive_code == `PPDC_DRV_DYNAMIC);
      low_drive[n]     = (drive_code == `PPDC_DRV_LOW);
    end
  end

endmodule // ppdc_nibble_decode

// ==== src/ppdc_top.v ====
// Port pad driver control bank: ten 16-bit registers behind an AHB-Lite
// slave, decoded into slow-edge, dynamic-drive and low-drive pad controls.
// Assumes a single AHB-Lite master, one clock, inputs synchronous to clock.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ppdc_regs.vh"

module ppdc_top (
  input  wire        clock,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  output wire [39:0] pad_slow_edge,
  output wire [39:0] pad_dynamic_drive,
  output wire [39:0] pad_low_drive
);

  // Map a word address onto a register slot; bit 4 flags a hit
  function [4:0] reg_lookup;
    input [31:0] addr;
    begin
      reg_lookup = 5'h00;
      if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
        case (addr[17:2])
          `PPDC_IDX_P0L: reg_lookup = 5'h10;
          `PPDC_IDX_P0H: reg_lookup = 5'h11;
          `PPDC_IDX_P1L: reg_lookup = 5'h12;
          `PPDC_IDX_P1H: reg_lookup = 5'h13;
          `PPDC_IDX_P2:  reg_lookup = 5'h14;
          `PPDC_IDX_P3:  reg_lookup = 5'h15;
          `PPDC_IDX_P4:  reg_lookup = 5'h16;
          `PPDC_IDX_P6:  reg_lookup = 5'h17;
          `PPDC_IDX_P7:  reg_lookup = 5'h18;
          `PPDC_IDX_P8:  reg_lookup = 5'h19;
          default:       reg_lookup = 5'h00;
        endcase
      end
    end
  endfunction

  // Only the port 2 and port 3 registers carry four nibbles
  function [15:0] reg_mask;
    input [3:0] idx;
    begin
      if (idx == 4'h4 || idx == 4'h5)
        reg_mask = `PPDC_MASK_WIDE;
      else
        reg_mask = `PPDC_MASK_NARROW;
    end
  endfunction

  // Read-back view of a register: bits with no pin group read zero
  function [31:0] read_word;
    input [15:0] value;
    input [3:0]  idx;
    begin
      read_word = {16'h0000, value & reg_mask(idx)};
    end
  endfunction

  // Byte lanes of a transfer from its size and low address bits
  function [1:0] lane_enable;
    input [2:0] size;
    input [1:0] low;
    begin
      case (size)
        3'h0:    lane_enable = {low == 2'h1, low == 2'h0};
        3'h1:    lane_enable = {low[1] == 1'b0, low[1] == 1'b0};
        default: lane_enable = 2'h3;
      endcase
    end
  endfunction

  reg  [15:0] ctl_r [0:9];
  reg         wr_pend_r;
  reg  [3:0]  wr_idx_r;
  reg  [1:0]  wr_lane_r;
  reg  [31:0] hrdata_r;
  reg  [39:0] pad_slow_edge_r;
  reg  [39:0] pad_dynamic_drive_r;
  reg  [39:0] pad_low_drive_r;

  wire        access;
  wire [4:0]  hit;
  wire [15:0] wr_mask;
  wire [15:0] wr_value;
  wire [1:0]  lane_now;
  wire [39:0] dec_slow_edge;
  wire [39:0] dec_dynamic_drive;
  wire [39:0] dec_low_drive;

  // Address phase is taken only when the bus is ready
  assign access   = hsel & hready & (htrans == `PPDC_HTRANS_NONSEQ |
                                     htrans == 2'h3);
  assign hit      = reg_lookup({haddr[31:2], 2'h0});
  assign lane_now = lane_enable(hsize, haddr[1:0]);
  assign wr_mask  = reg_mask(wr_idx_r) &
                    {{8{wr_lane_r[1]}}, {8{wr_lane_r[0]}}};
  assign wr_value = (ctl_r[wr_idx_r] & ~wr_mask) | (hwdata[15:0] & wr_mask);

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `PPDC_HRESP_OKAY;
  assign hrdata    = hrdata_r;

  // Pad controls leave the block from flip-flops
  assign pad_slow_edge     = pad_slow_edge_r;
  assign pad_dynamic_drive = pad_dynamic_drive_r;
  assign pad_low_drive     = pad_low_drive_r;

  // Remember a write for its data phase; unmapped writes are dropped
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'h0;
      wr_lane_r <= 2'h0;
    end else if (hready) begin
      wr_pend_r <= access & hwrite & hit[4];
      wr_idx_r  <= hit[3:0];
      wr_lane_r <= lane_now;
    end
  end

  // Register bank; bits without a pin group never store
  integer k;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < 10; k = k + 1) begin
        ctl_r[k] <= `PPDC_RESET_VALUE;
      end
    end else if (wr_pend_r) begin
      ctl_r[wr_idx_r] <= wr_value;
    end
  end

  // Read data is captured at the address phase; a write still in its data
  // phase to the same slot is forwarded so a read never sees stale data
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata_r <= 32'h00000000;
    end else if (access & ~hwrite) begin
      if (!hit[4])
        hrdata_r <= 32'h00000000;
      else if (wr_pend_r && wr_idx_r == hit[3:0])
        hrdata_r <= read_word(wr_value, hit[3:0]);
      else
        hrdata_r <= read_word(ctl_r[hit[3:0]], hit[3:0]);
    end
  end

  // One decoder per register; four pad slots per register in the outputs
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gen_dec
      ppdc_nibble_decode u_dec (
        .ctl_value     (ctl_r[g]),
        .slow_edge     (dec_slow_edge[g*4 +: 4]),
        .dynamic_drive (dec_dynamic_drive[g*4 +: 4]),
        .low_drive     (dec_low_drive[g*4 +: 4])
      );
    end
  endgenerate

  // Pads take the decoded modes one clock after the register write, so a
  // two-bit code change never shows a passing mode at the pad drivers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pad_slow_edge_r     <= 40'h0000000000;
      pad_dynamic_drive_r <= 40'h0000000000;
      pad_low_drive_r     <= 40'h0000000000;
    end else begin
      pad_slow_edge_r     <= dec_slow_edge;
      pad_dynamic_drive_r <= dec_dynamic_drive;
      pad_low_drive_r     <= dec_low_drive;
    end
  end

endmodule // ppdc_top

// ==== testbench/ppdc_top_sva.sv ====
// Checker for the pad control bank, bound to ppdc_top.
// Sees only top ports; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module ppdc_check (
  input logic        clock,
  input logic        resetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic [39:0] pad_slow_edge,
  input logic [39:0] pad_dynamic_drive,
  input logic [39:0] pad_low_drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Taken transfers; the wide port 2 register is probed field by field
  wire        tk   = hsel && hready && htrans[1];
  wire        p2w  = tk && hwrite && hsize == 3'h2 && haddr == 32'h3c220;
  wire [39:0] pads = pad_slow_edge | pad_dynamic_drive | pad_low_drive;
  property p_rst; $rose(resetn) |-> pads == 40'h0; endproperty
  a_rst: assert property (p_rst) else $error("pads set after reset");
  property p_gap; (pads & 40'hcc_cc00_cccc) == 40'h0; endproperty
  a_gap: assert property (p_gap) else $error("absent nibble active");
  property p_high; tk && !hwrite && haddr != 32'h3c220 && haddr != 32'h3c228
    |=> hrdata[31:8] == 24'h0; endproperty
  a_high: assert property (p_high) else $error("upper byte set");
  property p_chg; $changed(pads) |-> $past(tk && hwrite, 3); endproperty
  a_chg: assert property (p_chg) else $error("pads moved unwritten");
  property p_edge; p2w |-> ##3 pad_slow_edge[16] == ($past(hwdata[1:0], 2) == 2'h1);
  endproperty
  a_edge: assert property (p_edge) else $error("edge mode");
  property p_dyn; p2w |-> ##3 pad_dynamic_drive[16] == ($past(hwdata[3:2], 2) == 2'h1);
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic mode");
  property p_low; p2w |-> ##3 pad_low_drive[17] == ($past(hwdata[7:6], 2) == 2'h2);
  endproperty
  a_low: assert property (p_low) else $error("low mode");
  property p_top; p2w |-> ##3 pad_slow_edge[19] == ($past(hwdata[13:12], 2) == 2'h1);
  endproperty
  a_top: assert property (p_top) else $error("top nibble");
endmodule // ppdc_check
bind ppdc_top ppdc_check ppdc_check_i (.*);

// ==== testbench/ppdc_pad_model.sv ====
// Pad driver model fed by the decoded controls of the bank.
// Assumes four slots per register, as flattened by the top.
`timescale 1ns/1ps
module ppdc_pad_model (
  input  wire [39:0] dynamic_drive,
  input  wire [39:0] low_drive,
  output wire [39:0] reduced
);
  // Only dynamic and low modes leave full strength; code 11 stays high
  assign reduced = dynamic_drive | low_drive;
endmodule // ppdc_pad_model

// ==== testbench/port_pad_driver_control_tb.sv ====
// Self-checking bench for the pad control bank over AHB-Lite.
// Assumes one master; every transfer wait polls hready, watchdog ends hangs.
`timescale 1ns/1ps
module port_pad_driver_control_tb;
  logic        clock = 0, resetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire         hready, hresp;
  wire  [31:0] hrdata;
  wire  [39:0] slow, dyn, low, reduced;
  logic [15:0] model [10];
  int          num_errors = 0, cmp_count = 0;
  // Rows: written data beside expected read back; port 0 nibble 0 keeps a fast bus edge
  logic [15:0] row_w [10] = '{16'hffd4, 16'h12e1, 16'h0096, 16'ha578, 16'h5eb5,
                              16'h1b4e, 16'h5a0f, 16'h00b2, 16'h7c3d, 16'hffff};
  logic [15:0] row_e [10] = '{16'h00d4, 16'h00e1, 16'h0096, 16'h0078, 16'h5eb5,
                              16'h1b4e, 16'h000f, 16'h00b2, 16'h003d, 16'h00ff};
  ppdc_top ppdc_top_i (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pad_slow_edge(slow),
    .pad_dynamic_drive(dyn), .pad_low_drive(low));
  ppdc_pad_model ppdc_pad_model_i (.dynamic_drive(dyn), .low_drive(low), .reduced(reduced));
  initial forever #50 clock = ~clock;
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer; address held until hready, then the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input int r, input logic [15:0] e);
    xfer(1'b0, 32'h3c200 + 32'(r) * 32'h8, 32'h0);
    chk({158'h0, hready, hresp}, {158'h0, 2'h2});
    chk({128'h0, rd}, {144'h0, e});
  endtask
  // Expected pad controls from the register image, worked out per nibble
  function automatic logic [159:0] pads_exp();
    logic [3:0]  f;
    logic [39:0] s, dd, l;
    for (int i = 0; i < 40; i++) begin
      f = model[i / 4][4 * (i % 4) +: 4];
      s[i] = f[1:0] == 2'h1;
      dd[i] = f[3:2] == 2'h1;
      l[i] = f[3:2] == 2'h2;
    end
    return {s, dd, l, dd | l};
  endfunction
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 10; i++) model[i] = 16'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd_chk(i, 16'h0);
      xfer(1'b1, 32'h3c200 + 32'(i) * 32'h8, {16'hbeef, row_w[i]});
      model[i] = row_e[i];
      rd_chk(i, row_e[i]);
      chk({slow, dyn, low, reduced}, pads_exp());
    end
    // Unmapped word just past the bank must neither store nor disturb
    xfer(1'b1, 32'h3c250, 32'hffff_ffff);
    xfer(1'b0, 32'h3c250, 32'h0);
    chk({128'h0, rd}, 160'h0);
    chk({slow, dyn, low, reduced}, pads_exp());
    // Reset in mid-run clears every register and pad control
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) model[i] = 16'h0;
    chk({slow, dyn, low, reduced}, pads_exp());
    rd_chk(4, 16'h0);
    complete_run();
  end
endmodule // port_pad_driver_control_tb
